//--- thermal_fan_map.svh
// constants for the thermal monitor and fan controller
`ifndef THERMAL_FAN_MAP_SVH
`define THERMAL_FAN_MAP_SVH

`define TEMP_W        8
`define SPEED_W       8
`define SPEED_LOW     8'h40
`define SPEED_HOT     8'ha0
`define SPEED_MAX     8'hff
`define SPEED_OFF     8'h00
`define HI_LIM_RESET  8'h50
`define LO_LIM_RESET  8'h46
`define HOT_MARGIN    8'h0a

`endif

//--- thermal_fan_pkg.sv
// types for the thermal monitor and fan controller
package thermal_fan_pkg;

    typedef enum logic [3:0] {
        ST_NORMAL = 4'b0001,
        ST_HOT    = 4'b0010,
        ST_OVER   = 4'b0100,
        ST_SLEEP  = 4'b1000
    } fan_state_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic       load;
    } limit_load_t;

    typedef struct packed {
        logic sleep_req;
        logic psu_hot;
        logic small_chassis;
    } sys_cond_t;

endpackage

//--- thermal_fan_ctrl.sv
// thermal monitor and fan speed controller
// ============================================================
// What this block does
// - turn processor temperature into fan speed command
// - sleep asserts active-low fan shut-off
// - high limit reached: maximum speed, alert asserted
// - normal conditions command low fan speed
// - hot processor raises speed above low
// - hot part during sleep restarts fans
// - small chassis keeps cpu fan speed low under power supply heat, though supply heat still wakes fans
// - large chassis fans share one command
`timescale 1ns/10ps
`default_nettype none
`include "thermal_fan_map.svh"

module thermal_fan_ctrl (
    // clock and reset
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         clk_en_i,
    // temperature and limits
    input  wire logic [`TEMP_W-1:0]           temp_i,
    input  wire thermal_fan_pkg::limit_load_t limit_i,
    input  wire thermal_fan_pkg::sys_cond_t   cond_i,
    // fan and alert outputs
    output logic [`SPEED_W-1:0]               fan_speed_o,
    output logic                              fan_off_n_o,
    output logic                              over_temp_alert_n_o,
    output logic                              limits_valid_o
);

    // ============================================================
    // limit registers
    logic [`TEMP_W-1:0] hi_q, hi_d, lo_q, lo_d;
    logic               valid_q, valid_d;

    always_comb begin
        hi_d    = hi_q;
        lo_d    = lo_q;
        valid_d = valid_q;
        if (limit_i.load) begin
            // firmware writes both limits during self test
            hi_d    = limit_i.high;
            lo_d    = limit_i.low;
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_q    <= `HI_LIM_RESET;
            lo_q    <= `LO_LIM_RESET;
            valid_q <= 1'b0;
        end else if (clk_en_i) begin
            hi_q    <= hi_d;
            lo_q    <= lo_d;
            valid_q <= valid_d;
        end
    end

    // ============================================================
    // thermal state machine
    // hot threshold sits a margin under the high limit; saturate at 0
    function automatic logic is_hot(input logic [7:0] t,
                                    input logic [7:0] hi);
        logic [7:0] th;
        th = (hi > `HOT_MARGIN) ? 8'(hi - `HOT_MARGIN) : 8'h00;
        return t >= th;
    endfunction

    thermal_fan_pkg::fan_state_t st_q, st_d;
    logic [`SPEED_W-1:0]         spd_q, spd_d;
    logic                        off_n_q, off_n_d;
    logic                        alert_n_q, alert_n_d;
    logic                        over, cpu_hot, psu_eff;

    always_comb begin
        over    = temp_i >= hi_q;
        cpu_hot = is_hot(temp_i, hi_q);
        // small chassis: supply heat does not raise the cpu fan speed
        psu_eff = cond_i.psu_hot && !cond_i.small_chassis;
        st_d    = st_q;
        case (st_q)
            thermal_fan_pkg::ST_NORMAL: begin
                // a hot part keeps fans on, else sleep and wake would chatter
                if (over)
                    st_d = thermal_fan_pkg::ST_OVER;
                else if (cpu_hot)
                    st_d = thermal_fan_pkg::ST_HOT;
                else if (cond_i.sleep_req && !cond_i.psu_hot)
                    st_d = thermal_fan_pkg::ST_SLEEP;
            end
            thermal_fan_pkg::ST_HOT: begin
                if (over)
                    st_d = thermal_fan_pkg::ST_OVER;
                else if (!cpu_hot)
                    st_d = thermal_fan_pkg::ST_NORMAL;
            end
            thermal_fan_pkg::ST_OVER: begin
                // hysteresis stops the alert chattering near the limit
                if (temp_i < lo_q)
                    st_d = thermal_fan_pkg::ST_NORMAL;
            end
            thermal_fan_pkg::ST_SLEEP: begin
                if (over)
                    st_d = thermal_fan_pkg::ST_OVER;
                else if (cpu_hot)
                    st_d = thermal_fan_pkg::ST_HOT;
                // supply heat wakes to normal: small chassis cpu fan stays low
                else if (cond_i.psu_hot || !cond_i.sleep_req)
                    st_d = thermal_fan_pkg::ST_NORMAL;
            end
            default: st_d = thermal_fan_pkg::ST_NORMAL;
        endcase

        alert_n_d = (st_d != thermal_fan_pkg::ST_OVER);
        off_n_d   = (st_d != thermal_fan_pkg::ST_SLEEP);
        case (st_d)
            thermal_fan_pkg::ST_OVER:  spd_d = `SPEED_MAX;
            thermal_fan_pkg::ST_HOT:   spd_d = `SPEED_HOT;
            thermal_fan_pkg::ST_SLEEP: spd_d = `SPEED_OFF;
            default:                   spd_d = psu_eff ? `SPEED_HOT
                                                       : `SPEED_LOW;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q      <= thermal_fan_pkg::ST_NORMAL;
            spd_q     <= `SPEED_LOW;
            off_n_q   <= 1'b1;
            alert_n_q <= 1'b1;
        end else if (clk_en_i) begin
            st_q      <= st_d;
            spd_q     <= spd_d;
            off_n_q   <= off_n_d;
            alert_n_q <= alert_n_d;
        end
    end

    assign fan_speed_o         = spd_q;
    assign fan_off_n_o         = off_n_q;
    assign over_temp_alert_n_o = alert_n_q;
    assign limits_valid_o      = valid_q;

    // ============================================================
    // checks
    property p_over_alert;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && temp_i >= hi_q) |=> (!over_temp_alert_n_o
                                        && fan_speed_o == `SPEED_MAX);
    endproperty
    a_over_alert: assert property (p_over_alert)
        else $error("alert or max speed missing at high limit");

    property p_alert_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && !over_temp_alert_n_o && temp_i >= lo_q)
            |=> !over_temp_alert_n_o;
    endproperty
    a_alert_hold: assert property (p_alert_hold)
        else $error("alert cleared above low limit");

    property p_sleep_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && st_q == thermal_fan_pkg::ST_NORMAL && cond_i.sleep_req
         && !cond_i.psu_hot && !is_hot(temp_i, hi_q) && temp_i < hi_q)
            |=> !fan_off_n_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("fans not shut off on sleep");

    property p_wake_hot;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && !fan_off_n_o && (cond_i.psu_hot || is_hot(temp_i, hi_q)))
            |=> fan_off_n_o;
    endproperty
    a_wake_hot: assert property (p_wake_hot)
        else $error("hot part did not restart fans");

    property p_psu_keep;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && fan_off_n_o && cond_i.psu_hot) |=> fan_off_n_o;
    endproperty
    a_psu_keep: assert property (p_psu_keep)
        else $error("fans shut off while supply hot");

    property p_small_wake;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && !fan_off_n_o && cond_i.small_chassis && cond_i.psu_hot
         && !is_hot(temp_i, hi_q)) |=> (fan_off_n_o
                                        && fan_speed_o == `SPEED_LOW);
    endproperty
    a_small_wake: assert property (p_small_wake)
        else $error("small chassis wake not at low speed");

    property p_normal_low;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && st_q == thermal_fan_pkg::ST_NORMAL && !cond_i.sleep_req
         && !is_hot(temp_i, hi_q) && !cond_i.psu_hot) |=>
            fan_speed_o == `SPEED_LOW;
    endproperty
    a_normal_low: assert property (p_normal_low)
        else $error("normal speed not low");

    property p_hot_raise;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && fan_off_n_o && is_hot(temp_i, hi_q))
            |=> fan_speed_o > `SPEED_LOW;
    endproperty
    a_hot_raise: assert property (p_hot_raise)
        else $error("hot processor did not raise speed");

    property p_small_psu;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && cond_i.small_chassis && !cond_i.sleep_req
         && st_q == thermal_fan_pkg::ST_NORMAL && !is_hot(temp_i, hi_q))
            |=> fan_speed_o == `SPEED_LOW;
    endproperty
    a_small_psu: assert property (p_small_psu)
        else $error("supply heat moved small chassis fan");

    property p_large_psu;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && !cond_i.small_chassis && cond_i.psu_hot && fan_off_n_o)
            |=> fan_speed_o > `SPEED_LOW;
    endproperty
    a_large_psu: assert property (p_large_psu)
        else $error("supply heat ignored in large chassis");

    property p_limit_load;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (clk_en_i && limit_i.load) |=> (hi_q == $past(limit_i.high)
                                     && lo_q == $past(limit_i.low)
                                     && limits_valid_o);
    endproperty
    a_limit_load: assert property (p_limit_load)
        else $error("limit load not taken");

endmodule

`default_nettype wire

//--- fan_drive_model.sv
// behavioural model of fan power switching, speed logic and hub alert use
`timescale 1ns/10ps
`default_nettype none
`include "thermal_fan_map.svh"
module fan_drive_model (
    // from the controller
    input  wire logic [7:0] speed_cmd_i,
    input  wire logic       fan_off_n_i,
    input  wire logic       alert_n_i,
    // system side
    input  wire logic       psu_hot_i,
    input  wire logic       hub_cfg_i,
    // observed fan state
    output logic [7:0]      psu_fan_speed_o,
    output logic            fan_power_o,
    output logic            network_alert_message_o
);
    assign fan_power_o = fan_off_n_i;
    // supply heat lifts its own fan to at least hot speed unless fan power is off
    assign psu_fan_speed_o = !fan_power_o ? `SPEED_OFF :
        (psu_hot_i && speed_cmd_i < `SPEED_HOT) ? `SPEED_HOT : speed_cmd_i;
    // the hub only reacts when software enabled it
    assign network_alert_message_o = hub_cfg_i & ~alert_n_i;
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the thermal fan controller
`timescale 1ns/10ps
`default_nettype none
`include "thermal_fan_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] temp_i = 8'h30;
    thermal_fan_pkg::limit_load_t limit_i = '0;
    thermal_fan_pkg::sys_cond_t cond_i = '0;
    logic [7:0] fan_speed_o, psu_fan;
    logic fan_off_n_o, over_temp_alert_n_o, limits_valid_o, fan_pwr, msg;
    logic hub_cfg = 1'b1;
    int n_errors = 0;
    int total_checks = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    thermal_fan_ctrl thermal_fan_ctrl_i (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .temp_i(temp_i),
        .limit_i(limit_i), .cond_i(cond_i), .fan_speed_o(fan_speed_o),
        .fan_off_n_o(fan_off_n_o), .over_temp_alert_n_o(over_temp_alert_n_o),
        .limits_valid_o(limits_valid_o));
    fan_drive_model fan_drive_model_i (.speed_cmd_i(fan_speed_o),
        .fan_off_n_i(fan_off_n_o), .alert_n_i(over_temp_alert_n_o),
        .psu_hot_i(cond_i.psu_hot), .hub_cfg_i(hub_cfg),
        .psu_fan_speed_o(psu_fan), .fan_power_o(fan_pwr),
        .network_alert_message_o(msg));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #5;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_load();
        `CHK(fan_speed_o, `SPEED_LOW)
        `CHK(limits_valid_o, 1'b0)
        limit_i = '{high: 8'h60, low: 8'h50, load: 1'b1};
        step(1);
        limit_i.load = 1'b0;
        step(2);
        `CHK(limits_valid_o, 1'b1)
        $display("test load done");
    endtask
    task automatic t_levels();
        temp_i = 8'h55;
        step(3);
        `CHK(fan_speed_o, `SPEED_LOW)
        temp_i = 8'h56;
        step(3);
        `CHK(fan_speed_o, `SPEED_HOT)
        temp_i = 8'h60;
        step(3);
        `CHK(fan_speed_o, `SPEED_MAX)
        `CHK(over_temp_alert_n_o, 1'b0)
        `CHK(msg, 1'b1)
        temp_i = 8'h50;
        step(3);
        `CHK(over_temp_alert_n_o, 1'b0)
        `CHK(fan_speed_o, `SPEED_MAX)
        temp_i = 8'h4f;
        step(3);
        `CHK(over_temp_alert_n_o, 1'b1)
        `CHK(fan_speed_o, `SPEED_LOW)
        $display("test levels done");
    endtask
    task automatic t_sleep();
        int k;
        cond_i.sleep_req = 1'b1;
        step(3);
        `CHK(fan_off_n_o, 1'b0)
        `CHK(fan_pwr, 1'b0)
        for (int c = 0; c < 2; c++) begin
            cond_i.small_chassis = c[0];
            cond_i.psu_hot = 1'b1;
            k = 0;
            while (fan_off_n_o !== 1'b1 && k < 4) begin
                step(1);
                k++;
            end
            `CHK(fan_off_n_o, 1'b1)
            `CHK(fan_speed_o, c ? `SPEED_LOW : `SPEED_HOT)
            `CHK(psu_fan, `SPEED_HOT)
            step(3);
            `CHK(fan_off_n_o, 1'b1)
            cond_i.psu_hot = 1'b0;
            step(4);
            `CHK(fan_off_n_o, 1'b0)
        end
        temp_i = 8'h56;
        step(2);
        `CHK(fan_off_n_o, 1'b1)
        `CHK(fan_speed_o, `SPEED_HOT)
        temp_i = 8'h4f;
        step(3);
        `CHK(fan_off_n_o, 1'b0)
        cond_i = '0;
        step(3);
        `CHK(fan_off_n_o, 1'b1)
        $display("test sleep done");
    endtask
    task automatic t_chassis();
        cond_i.psu_hot = 1'b1;
        step(3);
        `CHK(fan_speed_o, `SPEED_HOT)
        `CHK(psu_fan, `SPEED_HOT)
        cond_i.small_chassis = 1'b1;
        step(3);
        `CHK(fan_speed_o, `SPEED_LOW)
        `CHK(psu_fan, `SPEED_HOT)
        cond_i = '0;
        clk_en_i = 1'b0;
        temp_i = 8'h70;
        step(4);
        `CHK(fan_speed_o, `SPEED_LOW)
        clk_en_i = 1'b1;
        step(3);
        `CHK(fan_speed_o, `SPEED_MAX)
        `CHK(msg, 1'b1)
        hub_cfg = 1'b0;
        step(1);
        `CHK(msg, 1'b0)
        hub_cfg = 1'b1;
        $display("test chassis done");
    endtask
    initial begin
        step(16);
        rst_n_i = 1'b1;
        step(2);
        t_load();
        t_levels();
        t_sleep();
        t_chassis();
        end_of_test();
    end
    // the tests need well under 200 cycles
    initial begin
        #100us;
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
